// >>> core/ndft_pkg.sv
/*
 Package for the controller register bank: register offsets, widths,
 reset values, tally ceiling and the carrier structs shared by the files.
 Assumes a single synchronous clock domain and an 8-bit register port.
*/
package ndft_pkg;

    // ************************************************
    // Register offsets (byte registers on a plain port)
    // ************************************************
    localparam logic [5:0] OFF_TX_PAGE_START   = 6'h00;
    localparam logic [5:0] OFF_TX_LEN_LOW      = 6'h01;
    localparam logic [5:0] OFF_TX_LEN_HIGH     = 6'h02;
    localparam logic [5:0] OFF_RING_FIRST      = 6'h03;
    localparam logic [5:0] OFF_RING_END        = 6'h04;
    localparam logic [5:0] OFF_RING_GUARD      = 6'h05;
    localparam logic [5:0] OFF_RING_WRITE      = 6'h06;
    localparam logic [5:0] OFF_LOCAL_NOW_LOW   = 6'h07;
    localparam logic [5:0] OFF_LOCAL_NOW_HIGH  = 6'h08;
    localparam logic [5:0] OFF_REM_START_LOW   = 6'h09;
    localparam logic [5:0] OFF_REM_START_HIGH  = 6'h0a;
    localparam logic [5:0] OFF_REM_LEN_LOW     = 6'h0b;
    localparam logic [5:0] OFF_REM_LEN_HIGH    = 6'h0c;
    localparam logic [5:0] OFF_REM_NOW_LOW     = 6'h0d;
    localparam logic [5:0] OFF_REM_NOW_HIGH    = 6'h0e;
    localparam logic [5:0] OFF_CONTROL         = 6'h0f;
    localparam logic [5:0] OFF_STATION_BASE    = 6'h10;
    localparam logic [5:0] OFF_HASH_BASE       = 6'h18;
    localparam logic [5:0] OFF_ALIGN_TALLY     = 6'h20;
    localparam logic [5:0] OFF_CHECKSUM_TALLY  = 6'h21;
    localparam logic [5:0] OFF_LOST_TALLY      = 6'h22;

    // ************************************************
    // Field positions and values
    // ************************************************
    localparam int CTRL_WATCH_ONLY_BIT = 0;
    localparam logic [7:0] REG_RESET      = 8'h00;
    localparam logic [7:0] PAGE_LOW_BYTE  = 8'h00;
    localparam logic [7:0] TALLY_CEILING  = 8'hc0;
    localparam logic [7:0] UNMAPPED_READ  = 8'h00;
    localparam logic [31:0] CRC_INIT      = 32'hffffffff;
    localparam logic [31:0] CRC_POLY      = 32'h04c11db7;
    localparam logic [5:0] DEST_BITS_LAST = 6'h2f;

    // ************************************************
    // Carriers
    // ************************************************
    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ndft_bus_t;

    typedef struct packed {
        logic frame_done;     // End of a received frame
        logic align_err;      // Frame ended off a byte boundary
        logic crc_err;        // Checksum mismatch
        logic no_buffer;      // No room to store the frame
    } ndft_rx_event_t;

    typedef struct packed {
        logic       word_step;  // Remote transfer of one word
        logic       byte_step;  // Remote transfer of one byte
        logic       rem_start;  // Reload remote pointers from start regs
    } ndft_rdma_t;

endpackage

// >>> core/ndft_tally.sv
/*
 One saturating 8-bit tally that clears when the processor reads it.
 Assumes inc and rd are one-cycle, synchronous pulses.
*/
`timescale 1ns/1ns
module ndft_tally (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic inc_in,
    input wire logic rd_in,
    output logic [7:0] count_out
);
    import ndft_pkg::*;

    typedef struct packed {
        logic [7:0] count;  // Present tally
    } ndft_tally_state_t;

    ndft_tally_state_t state;
    ndft_tally_state_t next_state;

    // ************************************************
    // Count logic
    // ************************************************
    // A read clears; an event in the read cycle lands as one so it is not lost
    always_comb begin
        next_state = state;
        if (rd_in) begin
            next_state.count = inc_in ? 8'h01 : 8'h00;
        end else if (inc_in && state.count < TALLY_CEILING) begin
            next_state.count = state.count + 8'h01;
        end
    end

    // Register the state
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state <= '0;
        end else if (ce_in) begin
            state <= next_state;
        end
    end

    assign count_out = state.count;
endmodule

// >>> core/ndft_hash.sv
/*
 Destination address serial check: CRC-32 over the 48 destination bits,
 latching the top six CRC bits as the hash index, and a bytewise match
 against the station address. Assumes one bit per strobe, bit 0 first.
*/
`timescale 1ns/1ns
module ndft_hash (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic start_in,
    input wire logic bit_valid_in,
    input wire logic bit_in,
    input wire logic [47:0] station_in,
    output logic done_out,
    output logic [5:0] hash_out,
    output logic station_hit_out,
    output logic group_out
);
    import ndft_pkg::*;

    typedef struct packed {
        logic [31:0] crc;      // Running CRC
        logic [5:0]  index;    // Bit counter
        logic [5:0]  hash;     // Latched hash index
        logic        hit;      // Station match so far
        logic        group;    // First bit seen
        logic        done;     // All 48 bits in
        logic [7:0]  shift;    // Byte assembly
    } ndft_hash_state_t;

    ndft_hash_state_t state;
    ndft_hash_state_t next_state;
    logic [31:0] crc_step;
    logic [7:0] byte_now;

    // ************************************************
    // Serial CRC and bytewise compare
    // ************************************************
    always_comb begin
        next_state = state;
        crc_step = {state.crc[30:0], 1'b0} ^ ((state.crc[31] ^ bit_in) ? CRC_POLY : 32'h0);
        byte_now = {bit_in, state.shift[7:1]};
        if (start_in) begin
            next_state = '0;
            next_state.crc = CRC_INIT;
            next_state.hit = 1'b1;
        end else if (bit_valid_in && !state.done) begin
            next_state.crc = crc_step;
            next_state.shift = byte_now;
            next_state.index = state.index + 6'h01;
            if (state.index == 6'h00) begin
                next_state.group = bit_in;
            end
            // Compare each completed byte with its station register
            if (state.index[2:0] == 3'h7) begin
                if (byte_now != station_in[{state.index[5:3], 3'h0} +: 8]) begin
                    next_state.hit = 1'b0;
                end
            end
            if (state.index == DEST_BITS_LAST) begin
                next_state.hash = crc_step[31:26];
                next_state.done = 1'b1;
            end
        end
    end

    // Register the state
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state <= '0;
        end else if (ce_in) begin
            state <= next_state;
        end
    end

    assign done_out = state.done;
    assign hash_out = state.hash;
    assign station_hit_out = state.hit;
    assign group_out = state.group;
endmodule

// >>> core/ndft_regs.sv
/*
 Register bank of the network controller: transmit and receive DMA
 pointers, remote DMA pointers, station and hash filter, tallies.
 Assumes a synchronous 8-bit register port with read data one cycle
 after the read strobe, and a buffer manager and receiver that drive
 the event inputs as one-cycle pulses.
*/
`timescale 1ns/1ns
module ndft_regs (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,

    // Bus
    input wire ndft_pkg::ndft_bus_t bus_in,
    input wire ndft_pkg::ndft_rx_event_t rx_in,
    input wire ndft_pkg::ndft_rdma_t rdma_in,

    // Filter
    input wire logic dest_start_in,
    input wire logic dest_bit_valid_in,
    input wire logic dest_bit_in,

    // DMA
    input wire logic tx_load_in,
    input wire logic local_step_in,
    input wire logic link_next_in,
    input wire logic [7:0] next_page_in,
    input wire logic rx_error_in,

    // Outputs
    output logic [7:0] rdata_out,
    output logic [15:0] tx_addr_out,
    output logic [15:0] tx_count_out,
    output logic [15:0] local_addr_out,
    output logic [15:0] remote_addr_out,
    output logic [15:0] remote_count_out,

    // Status
    output logic local_abort_out,
    output logic accept_out,
    output logic store_out,
    output logic [7:0] ring_first_page_out,
    output logic [7:0] ring_end_page_out
);
    import ndft_pkg::*;

    // ************************************************
    // State of the bank
    // ************************************************
    typedef struct packed {
        // Transmit
        logic [7:0]  tx_page;       // Transmit page start
        logic [15:0] tx_len;        // Transmit length

        // Ring
        logic [7:0]  ring_first;    // Ring first page
        logic [7:0]  ring_end;      // Ring end page
        logic [7:0]  ring_guard;    // Ring guard page
        logic [7:0]  ring_write;    // Ring write page

        // DMA
        logic [15:0] local_addr;    // Live local DMA address
        logic [15:0] rem_start;     // Remote start address
        logic [15:0] rem_len;       // Remote length
        logic [15:0] rem_addr;      // Live remote address
        logic [15:0] rem_count;     // Live remote count

        // Filter
        logic [47:0] station;       // Station address bytes
        logic [63:0] hash_bits;     // Hash filter bits
        logic        watch_only;    // Watch-only mode

        // Outputs
        logic [7:0]  rdata;         // Read data
        logic        abort;         // Local DMA aborted
        logic        accept;        // Last frame recognized
        logic        store;         // Last frame to be stored
        logic [15:0] tx_addr;       // Transmit address out
        logic [15:0] tx_count;      // Transmit count out
    } ndft_regs_state_t;

    ndft_regs_state_t state;
    ndft_regs_state_t next_state;

    // Tallies
    logic [7:0] align_count;
    logic [7:0] checksum_count;
    logic [7:0] lost_count;

    // Filter
    logic hash_done;
    logic [5:0] hash_index;
    logic station_hit;
    logic group_bit;
    logic recognized;

    // Read clears
    logic rd_align;
    logic rd_checksum;
    logic rd_lost;

    // ************************************************
    // Address filter
    // ************************************************
    ndft_hash u_hash (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .start_in(dest_start_in),
        .bit_valid_in(dest_bit_valid_in),
        .bit_in(dest_bit_in),
        .station_in(state.station),
        .done_out(hash_done),
        .hash_out(hash_index),
        .station_hit_out(station_hit),
        .group_out(group_bit)
    );

    // Physical needs the station match; group needs the selected hash bit
    always_comb begin
        recognized = 1'b0;
        if (hash_done) begin
            if (group_bit) begin
                recognized = state.hash_bits[hash_index];
            end else begin
                recognized = station_hit;
            end
        end
    end

    // ************************************************
    // Tallies
    // ************************************************
    // Read strobes double as clear strobes
    assign rd_align = bus_in.rd && bus_in.addr == OFF_ALIGN_TALLY;
    assign rd_checksum = bus_in.rd && bus_in.addr == OFF_CHECKSUM_TALLY;
    assign rd_lost = bus_in.rd && bus_in.addr == OFF_LOST_TALLY;

    // Alignment tally
    ndft_tally u_align (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .inc_in(rx_in.frame_done && rx_in.align_err && recognized),
        .rd_in(rd_align),
        .count_out(align_count)
    );

    // Checksum tally
    ndft_tally u_checksum (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .inc_in(rx_in.frame_done && rx_in.crc_err && recognized),
        .rd_in(rd_checksum),
        .count_out(checksum_count)
    );

    // Watch-only counts every recognized frame, else only those dropped
    ndft_tally u_lost (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .inc_in(rx_in.frame_done && recognized
                && (state.watch_only || rx_in.no_buffer)),
        .rd_in(rd_lost),
        .count_out(lost_count)
    );

    // ************************************************
    // Next state
    // ************************************************
    always_comb begin
        next_state = state;
        next_state.rdata = UNMAPPED_READ;

        // Register writes, one byte each
        if (bus_in.wr) begin
            case (bus_in.addr)
                OFF_TX_PAGE_START: next_state.tx_page = bus_in.wdata;
                OFF_TX_LEN_LOW: next_state.tx_len[7:0] = bus_in.wdata;
                OFF_TX_LEN_HIGH: next_state.tx_len[15:8] = bus_in.wdata;

                OFF_RING_FIRST: next_state.ring_first = bus_in.wdata;
                OFF_RING_END: next_state.ring_end = bus_in.wdata;
                OFF_RING_GUARD: next_state.ring_guard = bus_in.wdata;
                // Software is trusted to write this only at setup
                OFF_RING_WRITE: next_state.ring_write = bus_in.wdata;

                OFF_REM_START_LOW: next_state.rem_start[7:0] = bus_in.wdata;
                OFF_REM_START_HIGH: next_state.rem_start[15:8] = bus_in.wdata;
                OFF_REM_LEN_LOW: next_state.rem_len[7:0] = bus_in.wdata;
                OFF_REM_LEN_HIGH: next_state.rem_len[15:8] = bus_in.wdata;

                OFF_CONTROL: next_state.watch_only = bus_in.wdata[CTRL_WATCH_ONLY_BIT];
                default: begin
                    // Station and hash bytes live in two windows
                    if (bus_in.addr[5:3] == OFF_STATION_BASE[5:3]
                        && bus_in.addr[2:0] < 3'h6) begin
                        next_state.station[{bus_in.addr[2:0], 3'h0} +: 8] = bus_in.wdata;
                    end else if (bus_in.addr[5:3] == OFF_HASH_BASE[5:3]) begin
                        next_state.hash_bits[{bus_in.addr[2:0], 3'h0} +: 8] = bus_in.wdata;
                    end
                end
            endcase
        end

        // Register reads, answered one cycle later
        if (bus_in.rd) begin
            case (bus_in.addr)
                OFF_TX_PAGE_START: next_state.rdata = state.tx_page;
                OFF_TX_LEN_LOW: next_state.rdata = state.tx_len[7:0];
                OFF_TX_LEN_HIGH: next_state.rdata = state.tx_len[15:8];

                OFF_RING_FIRST: next_state.rdata = state.ring_first;
                OFF_RING_END: next_state.rdata = state.ring_end;
                OFF_RING_GUARD: next_state.rdata = state.ring_guard;
                OFF_RING_WRITE: next_state.rdata = state.ring_write;

                OFF_LOCAL_NOW_LOW: next_state.rdata = state.local_addr[7:0];
                OFF_LOCAL_NOW_HIGH: next_state.rdata = state.local_addr[15:8];

                OFF_REM_START_LOW: next_state.rdata = state.rem_start[7:0];
                OFF_REM_START_HIGH: next_state.rdata = state.rem_start[15:8];
                OFF_REM_LEN_LOW: next_state.rdata = state.rem_len[7:0];
                OFF_REM_LEN_HIGH: next_state.rdata = state.rem_len[15:8];
                OFF_REM_NOW_LOW: next_state.rdata = state.rem_addr[7:0];
                OFF_REM_NOW_HIGH: next_state.rdata = state.rem_addr[15:8];

                OFF_CONTROL: next_state.rdata = {7'h00, state.watch_only};

                OFF_ALIGN_TALLY: next_state.rdata = align_count;
                OFF_CHECKSUM_TALLY: next_state.rdata = checksum_count;
                OFF_LOST_TALLY: next_state.rdata = lost_count;
                default: begin
                    if (bus_in.addr[5:3] == OFF_STATION_BASE[5:3]
                        && bus_in.addr[2:0] < 3'h6) begin
                        next_state.rdata = state.station[{bus_in.addr[2:0], 3'h0} +: 8];
                    end else if (bus_in.addr[5:3] == OFF_HASH_BASE[5:3]) begin
                        next_state.rdata = state.hash_bits[{bus_in.addr[2:0], 3'h0} +: 8];
                    end
                end
            endcase
        end

        // Transmit load: page start, low byte zero, full 16-bit count
        if (tx_load_in) begin
            next_state.tx_addr = {state.tx_page, PAGE_LOW_BYTE};
            next_state.tx_count = state.tx_len;
            next_state.local_addr = {state.tx_page, PAGE_LOW_BYTE};
        end else if (rx_error_in) begin
            // Rewind to the first page of the failed frame
            next_state.local_addr = {state.ring_write, PAGE_LOW_BYTE};
            // A guard hit in the same cycle still aborts
            next_state.abort = link_next_in && next_page_in == state.ring_guard;
        end else if (link_next_in) begin
            if (next_page_in == state.ring_guard) begin
                next_state.abort = 1'b1;
            end else begin
                next_state.local_addr = {next_page_in, PAGE_LOW_BYTE};
            end
        end else if (local_step_in && !state.abort) begin
            next_state.local_addr = state.local_addr + 16'h0001;
        end

        // Remote DMA pointers
        // Reload wins over a step
        if (rdma_in.rem_start) begin
            next_state.rem_addr = state.rem_start;
            next_state.rem_count = state.rem_len;
        end else if (rdma_in.word_step) begin
            next_state.rem_addr = state.rem_addr + 16'h0002;
            next_state.rem_count = state.rem_count - 16'h0002;
        end else if (rdma_in.byte_step) begin
            next_state.rem_addr = state.rem_addr + 16'h0001;
            next_state.rem_count = state.rem_count - 16'h0001;
        end

        // Frame verdict; watch-only never stores
        if (rx_in.frame_done) begin
            next_state.accept = recognized;
            next_state.store = recognized && !state.watch_only && !rx_in.no_buffer;
        end
    end

    // ************************************************
    // State register
    // ************************************************
    // Frozen while ce_in is low
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state <= '0;
        end else if (ce_in) begin
            state <= next_state;
        end
    end

    // Registered outputs
    assign rdata_out = state.rdata;

    assign tx_addr_out = state.tx_addr;
    assign tx_count_out = state.tx_count;

    assign local_addr_out = state.local_addr;

    assign remote_addr_out = state.rem_addr;
    assign remote_count_out = state.rem_count;

    assign local_abort_out = state.abort;

    assign accept_out = state.accept;
    assign store_out = state.store;

    assign ring_first_page_out = state.ring_first;
    assign ring_end_page_out = state.ring_end;
endmodule

// >>> bench/ndft_chk.sv
/*
 Checker for the register bank: read port, remote pointers, tallies.
 Assumes one clock domain; bound to every ndft_regs instance.
*/
`timescale 1ns/1ns
module ndft_chk (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire ndft_pkg::ndft_bus_t bus_in,
    input wire ndft_pkg::ndft_rx_event_t rx_in,
    input wire ndft_pkg::ndft_rdma_t rdma_in,
    input wire logic [7:0] rdata_out,
    input wire logic [15:0] tx_addr_out,
    input wire logic [15:0] remote_addr_out,
    input wire logic [15:0] remote_count_out,
    input wire logic accept_out
);
    import ndft_pkg::*;
    // ****
    // Step decode
    // ****
    logic ws; // Word step that wins priority
    logic bs; // Byte step that wins priority
    assign ws = ce_in && rdma_in.word_step && !rdma_in.rem_start;
    assign bs = ce_in && rdma_in.byte_step && !rdma_in.word_step && !rdma_in.rem_start;
    // ****
    // Properties
    // ****
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    rdata_idle_a: assert property (ce_in && !bus_in.rd |=> rdata_out == 8'h00)
        else $error("read data not zero outside a read");
    tx_page_a: assert property (tx_addr_out[7:0] == PAGE_LOW_BYTE)
        else $error("transmit start not on a page");
    word_addr_a: assert property (ws |=> remote_addr_out == $past(remote_addr_out) + 16'h2)
        else $error("remote address word step wrong");
    byte_addr_a: assert property (bs |=> remote_addr_out == $past(remote_addr_out) + 16'h1)
        else $error("remote address byte step wrong");
    word_count_a: assert property (ws |=> remote_count_out == $past(remote_count_out) - 16'h2)
        else $error("remote count word step wrong");
    byte_count_a: assert property (bs |=> remote_count_out == $past(remote_count_out) - 16'h1)
        else $error("remote count byte step wrong");
    tally_cap_a: assert property (ce_in && bus_in.rd && bus_in.addr >= OFF_ALIGN_TALLY &&
        bus_in.addr <= OFF_LOST_TALLY |=> rdata_out <= TALLY_CEILING)
        else $error("tally above ceiling");
    verdict_hold_a: assert property (ce_in && !rx_in.frame_done |=> $stable(accept_out))
        else $error("accept changed without frame end");
endmodule
bind ndft_regs ndft_chk i_chk (.clk_in, .rst_in, .ce_in, .bus_in, .rx_in, .rdma_in, .rdata_out,
    .tx_addr_out, .remote_addr_out, .remote_count_out, .accept_out);

// >>> bench/ndft_regs_tb.sv
/*
 Self-checking bench for the register bank: bus tasks, frames, tallies.
 Assumes the package offsets and a one-cycle read latency.
*/
`timescale 1ns/1ns
module ndft_regs_tb;
    import ndft_pkg::*;
    localparam logic [47:0] STA = 48'h5e4d3c2b1a00; // Physical, bit 0 clear
    localparam logic [47:0] GRP = 48'h0000005e0001; // Group, bit 0 set
    logic clk_in, rst_in, ce_in, dest_start_in, dest_bit_valid_in, dest_bit_in;
    logic tx_load_in, local_step_in, link_next_in, rx_error_in;
    logic local_abort_out, accept_out, store_out;
    logic [7:0] next_page_in, rdata_out, ring_first_page_out, ring_end_page_out;
    logic [15:0] tx_addr_out, tx_count_out, local_addr_out, remote_addr_out, remote_count_out;
    logic [5:0] h; // Hash of the group address
    ndft_bus_t bus_in;
    ndft_rx_event_t rx_in;
    ndft_rdma_t rdma_in;
    int num_errors, n_checks;
    ndft_regs i_dut (.clk_in, .rst_in, .ce_in, .bus_in, .rx_in, .rdma_in, .dest_start_in,
        .dest_bit_valid_in, .dest_bit_in, .tx_load_in, .local_step_in, .link_next_in,
        .next_page_in, .rx_error_in, .rdata_out, .tx_addr_out, .tx_count_out, .local_addr_out,
        .remote_addr_out, .remote_count_out, .local_abort_out, .accept_out, .store_out,
        .ring_first_page_out, .ring_end_page_out);
    // ****
    // Clock and helpers
    // ****
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_in);
        bus_in <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_in);
        bus_in <= '0;
    endtask
    // Read data is looked at in the one cycle where it stands
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        @(posedge clk_in);
        bus_in <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_in);
        bus_in <= '0;
        @(negedge clk_in);
        chk("rdata", {8'h00, rdata_out}, {8'h00, e});
    endtask
    task automatic link(input logic [7:0] p);
        @(posedge clk_in);
        link_next_in <= 1'b1;
        next_page_in <= p;
        @(posedge clk_in);
        link_next_in <= 1'b0;
        @(negedge clk_in);
    endtask
    // Destination bits go out bit 0 first, then the end-of-frame event
    task automatic frame(input logic [47:0] da, input logic [3:0] ev);
        @(posedge clk_in);
        dest_start_in <= 1'b1;
        for (int i = 0; i < 48; i++) begin
            @(posedge clk_in);
            dest_start_in <= 1'b0;
            dest_bit_valid_in <= 1'b1;
            dest_bit_in <= da[i];
        end
        @(posedge clk_in);
        dest_bit_valid_in <= 1'b0;
        rx_in <= ev;
        @(posedge clk_in);
        rx_in <= '0;
        @(negedge clk_in);
    endtask
    // Serial CRC, shifted in bit 0 first as in the filter
    function automatic logic [5:0] hash_of(input logic [47:0] da);
        logic [31:0] c;
        c = CRC_INIT;
        for (int i = 0; i < 48; i++)
            c = {c[30:0], 1'b0} ^ ((c[31] ^ da[i]) ? CRC_POLY : 32'h0);
        return c[31:26];
    endfunction
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ****
    // Watchdog, about four times the expected run
    // ****
    initial begin
        repeat (40000) @(posedge clk_in);
        num_errors++;
        give_verdict();
    end
    // ****
    // Tests
    // ****
    initial begin
        {rst_in, ce_in, dest_start_in, dest_bit_valid_in, dest_bit_in} = 5'b11000;
        {tx_load_in, local_step_in, link_next_in, rx_error_in, next_page_in} = '0;
        {bus_in, rx_in, rdma_in} = '0;
        repeat (5) @(posedge clk_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 8; i++) rd(OFF_HASH_BASE + 6'(i), REG_RESET);
        for (int i = 0; i < 6; i++) wr(OFF_STATION_BASE + 6'(i), STA[8*i +: 8]);
        for (int i = 0; i < 6; i++) rd(OFF_STATION_BASE + 6'(i), STA[8*i +: 8]);
        wr(OFF_LOCAL_NOW_LOW, 8'h77);
        rd(OFF_LOCAL_NOW_LOW, 8'h00);
        rd(6'h3f, UNMAPPED_READ);
        wr(OFF_RING_FIRST, 8'h40);
        wr(OFF_RING_END, 8'h60);
        @(negedge clk_in);
        chk("ring", {ring_first_page_out, ring_end_page_out}, 16'h4060);
        $display("test registers done");
        wr(OFF_TX_PAGE_START, 8'ha5);
        wr(OFF_TX_LEN_LOW, 8'hff);
        wr(OFF_TX_LEN_HIGH, 8'hff);
        @(posedge clk_in);
        tx_load_in <= 1'b1;
        @(posedge clk_in);
        tx_load_in <= 1'b0;
        @(negedge clk_in);
        chk("tx_addr", tx_addr_out, 16'ha500);
        chk("tx_count", tx_count_out, 16'hffff);
        $display("test transmit done");
        wr(OFF_REM_START_LOW, 8'hfe);
        wr(OFF_REM_START_HIGH, 8'h12);
        wr(OFF_REM_LEN_LOW, 8'h05);
        wr(OFF_REM_LEN_HIGH, 8'h00);
        rd(OFF_REM_START_HIGH, 8'h12);
        @(posedge clk_in);
        rdma_in <= 3'b001;
        @(posedge clk_in);
        rdma_in <= 3'b100;
        @(posedge clk_in);
        rdma_in <= 3'b010;
        @(posedge clk_in);
        rdma_in <= 3'b000;
        @(negedge clk_in);
        chk("rem_addr", remote_addr_out, 16'h1301);
        chk("rem_count", remote_count_out, 16'h0002);
        rd(OFF_REM_NOW_LOW, 8'h01);
        rd(OFF_REM_NOW_HIGH, 8'h13);
        $display("test remote done");
        wr(OFF_RING_GUARD, 8'h47);
        wr(OFF_RING_WRITE, 8'h40);
        link(8'h46);
        chk("abort", {15'h0, local_abort_out}, 16'h0);
        link(8'h47);
        chk("abort", {15'h0, local_abort_out}, 16'h1);
        @(posedge clk_in);
        rx_error_in <= 1'b1;
        @(posedge clk_in);
        rx_error_in <= 1'b0;
        @(negedge clk_in);
        chk("restore", local_addr_out, 16'h4000);
        rd(OFF_LOCAL_NOW_HIGH, 8'h40);
        rd(OFF_LOCAL_NOW_LOW, 8'h00);
        @(posedge clk_in);
        local_step_in <= 1'b1;
        @(posedge clk_in);
        local_step_in <= 1'b0;
        rd(OFF_LOCAL_NOW_LOW, 8'h01);
        $display("test ring done");
        frame(STA, 4'b1000);
        chk("accept", {14'h0, accept_out, store_out}, 16'h3);
        frame(STA ^ 48'h100, 4'b1000);
        chk("accept", {15'h0, accept_out}, 16'h0);
        h = hash_of(GRP);
        frame(GRP, 4'b1000);
        chk("accept", {15'h0, accept_out}, 16'h0);
        wr(OFF_HASH_BASE + {3'h0, h[5:3]}, 8'h01 << h[2:0]);
        frame(GRP, 4'b1000);
        chk("accept", {15'h0, accept_out}, 16'h1);
        $display("test filter done");
        repeat (194) frame(GRP, 4'b1111);
        for (int i = 0; i < 3; i++) rd(OFF_ALIGN_TALLY + 6'(i), TALLY_CEILING);
        for (int i = 0; i < 3; i++) rd(OFF_ALIGN_TALLY + 6'(i), 8'h00);
        frame(STA ^ 48'h100, 4'b1110);
        rd(OFF_ALIGN_TALLY, 8'h00);
        rd(OFF_CHECKSUM_TALLY, 8'h00);
        $display("test tallies done");
        wr(OFF_CONTROL, 8'h01);
        frame(STA, 4'b1000);
        chk("store", {15'h0, store_out}, 16'h0);
        rd(OFF_LOST_TALLY, 8'h01);
        $display("test watch done");
        give_verdict();
    end
endmodule
